// ### common/sdal_pkg.sv
// constants shared by both ends of the serial debug acquire and lock link
// assumes both ends run on one 250 MHz core clock with a synchronous reset
// How it works
// - host link clock at most CPU clock/3
// - two pins: host clock, shared data wire
// - serial port active on one pair only
// - pair opens on pattern within 8 us
// - reacquire allowed inside the key window unless locked, then JTAG re-enable
// - JTAG side enables/disables; disabled pins GPIO
// - all debug functions, no scan chain
// - only three debug plus trace pairings legal
// - pin counts per debug/trace configuration
// - protection lowers only via full erase
// - block operations other than verify need block security permission
// - 32-bit latch, set if 28 bits match
// - lock blocks debug, test, latch changes
// - lock sampled at reset only
// - key write only with no protection
// - host: key, program cells, protection, then reset
// - latch contents readable over serial link
// - six address, two literal breakpoint comparators
package sdal_pkg;
    localparam int CORE_MHZ = 250;
    localparam int KEY_WIN_US = 8;
    localparam logic [11:0] KEY_WIN_CYC = 12'(KEY_WIN_US * CORE_MHZ);
    localparam int LINK_DIV = 3;
    localparam int LINK_HALF_CYC = 6;
    localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);
    localparam logic [3:0] BIT_LAST = 4'(2 * LINK_HALF_CYC - 1);
    // acquisition pattern value is arbitrary
    localparam logic [15:0] ACQ_KEY = 16'hB2C5;
    localparam int ACQ_W = 16;
    localparam int CMD_W = 8;
    localparam int FRAME_W = 40;
    // lock key value is arbitrary
    localparam logic [31:0] LOCK_KEY = 32'h1A2B3C4D;
    localparam int LOCK_MATCH_MIN = 28;
    localparam int NBP = 8;
    localparam int NBP_PC = 6;
    localparam int NBLK = 16;
    // frame opcodes, low nibble of the command byte
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_RD_LOCK = 4'h1;
    localparam logic [3:0] OP_WR_LOCK = 4'h2;
    localparam logic [3:0] OP_PRG_LOCK = 4'h3;
    localparam logic [3:0] OP_SET_PROT = 4'h4;
    localparam logic [3:0] OP_ERASE_ALL = 4'h5;
    localparam logic [3:0] OP_BLK = 4'h6;
    localparam logic [3:0] OP_SET_CFG = 4'h7;
    localparam logic [3:0] OP_SET_BP = 4'h8;
    localparam logic [3:0] OP_RD_STAT = 4'h9;
    localparam logic [3:0] OP_SCAN = 4'hA;
    localparam logic [1:0] BLK_VERIFY = 2'h2;
    localparam logic [1:0] PROT_MAX = 2'h3;
    // debug, trace and pair function codes
    localparam logic [1:0] DBG_OFF = 2'h0;
    localparam logic [1:0] DBG_JTAG = 2'h1;
    localparam logic [1:0] DBG_SERIAL = 2'h2;
    localparam logic [1:0] TR_NONE = 2'h0;
    localparam logic [1:0] TR_SINGLE = 2'h1;
    localparam logic [1:0] TR_PAR = 2'h2;
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_JTAG = 2'h1;
    localparam logic [1:0] FN_SERIAL = 2'h2;
    localparam logic [3:0] PINS_JTAG = 4'h4;
    localparam logic [3:0] PINS_SERIAL = 4'h2;
    localparam logic [3:0] PINS_SINGLE = 4'h1;
    localparam logic [3:0] PINS_PAR = 4'h5;
    // config word fields
    localparam int CFG_DBG = 0;
    localparam int CFG_TRACE = 2;
    localparam int CFG_TRST = 4;
    localparam int CFG_SER_OFF = 5;
    // status word fields
    localparam int ST_REFUSED = 0;
    localparam int ST_LOCKED = 1;
    localparam int ST_PAIR = 2;
    localparam int ST_ACQ = 3;
    localparam int ST_PROT = 4;
    localparam int ST_DBG = 6;
    localparam int ST_TRACE = 8;
    localparam int ST_TRST = 10;
endpackage

// ### common/sdal_link_if.sv
// the two pin pairs between host and device: clock plus shared data wire
// assumes a pull-up on each data wire; contention is not modelled
`timescale 1ns/1ps
interface sdal_link_if;
    logic [1:0] lck;
    logic [1:0] h_do;
    logic [1:0] h_oe;
    logic [1:0] d_do;
    logic [1:0] d_oe;
    logic [1:0] line;
    // resolved wire level, host wins, idle pulls high
    assign line = (h_oe & h_do) | (~h_oe & d_oe & d_do) | (~h_oe & ~d_oe);
    modport dev (input lck, input line, output d_do, output d_oe);
    modport host (output lck, output h_do, output h_oe, input line);
endinterface

// ### rtl/sdal_dev.sv
// device end: key window acquisition, frame decode, lock latch, config,
// flash protection gate and breakpoint comparators
// assumes por_in only at power-up; nonvolatile state survives sys_rst_in
`timescale 1ns/1ps
module sdal_dev import sdal_pkg::*; (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic por_in,
    sdal_link_if.dev link,
    input wire logic jtag_cfg_we_in,
    input wire logic [5:0] jtag_cfg_in,
    input wire logic [NBLK-1:0] blk_lock_in,
    input wire logic [31:0] cpu_pc_in,
    input wire logic [31:0] cpu_lit_in,
    output logic locked_out,
    output logic test_allow_out,
    output logic [1:0] pair0_fn_out,
    output logic [1:0] pair1_fn_out,
    output logic [1:0] trace_out,
    output logic [3:0] pins_used_out,
    output logic [1:0] prot_out,
    output logic erase_all_out,
    output logic flash_go_out,
    output logic [1:0] flash_op_out,
    output logic [3:0] flash_blk_out,
    output logic [NBP-1:0] bp_hit_out
);
    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic lock_match(input logic [31:0] v);
        int n;
        n = 0;
        for (int i = 0; i < 32; i++) begin
            if (v[i] == LOCK_KEY[i]) begin
                n = n + 1;
            end
        end
        return n >= LOCK_MATCH_MIN;
    endfunction

    // trace and debug together only in three pairings
    function automatic logic cfg_legal(input logic [1:0] d, input logic [1:0] t);
        if (d == DBG_OFF || t == TR_NONE) begin
            return (d != 2'h3) && (t != 2'h3);
        end
        return (d == DBG_SERIAL) || (d == DBG_JTAG && t == TR_PAR);
    endfunction

    function automatic logic [3:0] pins(input logic [1:0] d, input logic [1:0] t,
                                        input logic trst);
        logic [3:0] n;
        n = 4'h0;
        if (d == DBG_JTAG) begin
            n = PINS_JTAG + {3'h0, trst};
        end
        if (d == DBG_SERIAL) begin
            n = PINS_SERIAL;
        end
        if (t == TR_SINGLE) begin
            n = n + PINS_SINGLE;
        end
        if (t == TR_PAR) begin
            n = n + PINS_PAR;
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, both pairs
    logic [1:0] clk_s1_ff, clk_s2_ff, clk_d_ff, dat_s1_ff, dat_s2_ff;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            clk_s1_ff <= 2'h0;
            clk_s2_ff <= 2'h0;
            clk_d_ff <= 2'h0;
            dat_s1_ff <= 2'h0;
            dat_s2_ff <= 2'h0;
        end else begin
            clk_s1_ff <= link.lck;
            clk_s2_ff <= clk_s1_ff;
            clk_d_ff <= clk_s2_ff;
            dat_s1_ff <= link.line;
            dat_s2_ff <= dat_s1_ff;
        end
    end
    wire [1:0] rise = clk_s2_ff & ~clk_d_ff;
    wire [1:0] fall = ~clk_s2_ff & clk_d_ff;

    ////////////////////////////////////////////////////////////////////
    // key window and acquisition
    logic [11:0] win_ff;
    logic [15:0] acq_sh_ff [2];
    logic acq_ff, pair_ff, locked_ff;
    logic [31:0] lock_nv_ff, lock_vol_ff;
    logic [1:0] prot_ff, dbg_ff, trc_ff;
    logic trst_ff, ser_off;
    wire win_open = win_ff < KEY_WIN_CYC;
    wire [1:0] hit;
    assign hit[0] = rise[0] && {dat_s2_ff[0], acq_sh_ff[0][15:1]} == ACQ_KEY;
    assign hit[1] = rise[1] && {dat_s2_ff[1], acq_sh_ff[1][15:1]} == ACQ_KEY;
    // a locked part never opens, even a previously disabled one otherwise does
    wire acq_go = win_open && !acq_ff && !locked_ff && (hit != 2'h0);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            win_ff <= 12'h0;
            acq_ff <= 1'b0;
            pair_ff <= 1'b0;
            locked_ff <= lock_match(lock_nv_ff);
            acq_sh_ff[0] <= 16'h0;
            acq_sh_ff[1] <= 16'h0;
        end else begin
            if (win_open) begin
                win_ff <= win_ff + 12'h1;
            end
            for (int p = 0; p < 2; p++) begin
                if (rise[p]) begin
                    acq_sh_ff[p] <= {dat_s2_ff[p], acq_sh_ff[p][15:1]};
                end
            end
            if (acq_go) begin
                acq_ff <= 1'b1;
                pair_ff <= !hit[0]; // pair 0 wins a tie
            end else if (ser_off) begin
                acq_ff <= 1'b0; // pair 0 falls back to jtag or gpio per the new config, pair 1 to gpio
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame shifter on the selected pair only
    wire srise = acq_ff && rise[pair_ff];
    wire sfall = acq_ff && fall[pair_ff];
    wire sdat = dat_s2_ff[pair_ff];
    logic [5:0] cnt_ff;
    logic [39:0] fr_ff;
    logic [31:0] rbuf_ff;
    logic rd_ff, do_ff, oe_ff, refused_ff;
    wire [39:0] word = {sdat, fr_ff[39:1]};
    wire [7:0] cmd_now = {sdat, fr_ff[39:33]};
    wire exec = srise && cnt_ff == 6'(FRAME_W - 1);
    wire [3:0] op = word[3:0];
    wire [3:0] arg = word[7:4];
    wire [31:0] wd = word[39:8];
    wire is_rd = cmd_now[3:0] == OP_RD_LOCK || cmd_now[3:0] == OP_RD_STAT;
    wire [31:0] stat = {21'h0, trst_ff, trc_ff, dbg_ff, prot_ff, acq_ff, pair_ff,
                        locked_ff, refused_ff};

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !acq_ff) begin
            cnt_ff <= 6'h0;
            fr_ff <= 40'h0;
            rd_ff <= 1'b0;
            rbuf_ff <= 32'h0;
            do_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (srise) begin
            fr_ff <= word;
            cnt_ff <= cnt_ff + 6'h1;
            if (cnt_ff == 6'(CMD_W - 1)) begin
                rd_ff <= is_rd;
                rbuf_ff <= (cmd_now[3:0] == OP_RD_LOCK) ? lock_nv_ff : stat;
            end
        end else if (sfall) begin
            if (cnt_ff == 6'(FRAME_W)) begin
                cnt_ff <= 6'h0; // release wire after the last read bit
                oe_ff <= 1'b0;
                rd_ff <= 1'b0;
            end else if (rd_ff && cnt_ff >= 6'(CMD_W)) begin
                oe_ff <= 1'b1;
                do_ff <= rbuf_ff[0];
                rbuf_ff <= {1'b0, rbuf_ff[31:1]};
            end
        end
    end
    assign link.d_do = {do_ff & pair_ff, do_ff & ~pair_ff};
    assign link.d_oe = {oe_ff & pair_ff, oe_ff & ~pair_ff};

    ////////////////////////////////////////////////////////////////////
    // command effects
    wire [1:0] blk_op = arg[1:0];
    wire [3:0] blk = wd[3:0];
    wire wr_lock_ok = exec && op == OP_WR_LOCK && prot_ff == 2'h0 && !locked_ff;
    wire prg_lock_ok = exec && op == OP_PRG_LOCK && !locked_ff;
    wire prot_ok = exec && op == OP_SET_PROT && arg[1:0] >= prot_ff;
    wire erase_ok = exec && op == OP_ERASE_ALL;
    wire blk_ok = exec && op == OP_BLK && blk_op <= BLK_VERIFY
                  && (!blk_lock_in[blk] || blk_op == BLK_VERIFY);
    wire cfg_ok = exec && op == OP_SET_CFG
                  && cfg_legal(wd[CFG_DBG +: 2], wd[CFG_TRACE +: 2]);
    wire jcfg_ok = jtag_cfg_we_in && !locked_ff && dbg_ff == DBG_JTAG
                   && cfg_legal(jtag_cfg_in[CFG_DBG +: 2], jtag_cfg_in[CFG_TRACE +: 2]);
    wire bp_ok = exec && op == OP_SET_BP;
    wire rd_ok = exec && (op == OP_RD_LOCK || op == OP_RD_STAT || op == OP_NOP);
    // scan requests fall through to refused: no chain on this port
    wire refuse = exec && !(wr_lock_ok || prg_lock_ok || prot_ok || erase_ok || blk_ok
                            || cfg_ok || bp_ok || rd_ok);
    wire [5:0] cfg_w = cfg_ok ? wd[5:0] : jtag_cfg_in;
    assign ser_off = (cfg_ok || jcfg_ok) && cfg_w[CFG_SER_OFF];

    // nonvolatile state: only power-up resets it, sys_rst_in does not
    always_ff @(posedge core_clk_in) begin
        if (por_in) begin
            lock_nv_ff <= 32'h0;
            prot_ff <= 2'h0;
            dbg_ff <= DBG_JTAG;
            trc_ff <= TR_NONE;
            trst_ff <= 1'b0;
        end else begin
            if (prg_lock_ok) begin
                lock_nv_ff <= lock_vol_ff;
            end
            if (erase_ok) begin
                prot_ff <= 2'h0;
            end else if (prot_ok) begin
                prot_ff <= arg[1:0];
            end
            if (cfg_ok || jcfg_ok) begin
                dbg_ff <= cfg_w[CFG_DBG +: 2];
                trc_ff <= cfg_w[CFG_TRACE +: 2];
                trst_ff <= cfg_w[CFG_TRST];
            end
        end
    end

    // volatile latch stage and breakpoints
    logic [31:0] bp_addr_ff [NBP];
    logic [NBP-1:0] bp_en_ff;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            lock_vol_ff <= 32'h0;
            refused_ff <= 1'b0;
            bp_en_ff <= '0;
            for (int i = 0; i < NBP; i++) begin
                bp_addr_ff[i] <= 32'h0;
            end
        end else begin
            if (wr_lock_ok) begin
                lock_vol_ff <= wd;
            end
            if (exec) begin
                refused_ff <= refuse;
            end
            if (bp_ok) begin
                bp_addr_ff[arg[2:0]] <= wd;
                bp_en_ff[arg[2:0]] <= arg[3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    logic [NBP-1:0] nxt_hit;
    always_comb begin
        for (int i = 0; i < NBP; i++) begin
            // six program address, two literal comparators
            nxt_hit[i] = bp_en_ff[i] && !locked_ff
                         && bp_addr_ff[i] == ((i < NBP_PC) ? cpu_pc_in : cpu_lit_in);
        end
    end
    wire [1:0] eff_dbg = acq_ff ? DBG_SERIAL : (locked_ff ? DBG_OFF : dbg_ff);
    // without acquisition pair 0 is jtag only if unlocked and configured jtag, else gpio; pair 1 is gpio
    wire [1:0] nxt_p0 = (acq_ff && !pair_ff) ? FN_SERIAL
                        : (eff_dbg == DBG_JTAG ? FN_JTAG : FN_GPIO);
    wire [1:0] nxt_p1 = (acq_ff && pair_ff) ? FN_SERIAL : FN_GPIO;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            locked_out <= 1'b0;
            test_allow_out <= 1'b0;
            pair0_fn_out <= FN_GPIO;
            pair1_fn_out <= FN_GPIO;
            trace_out <= TR_NONE;
            pins_used_out <= 4'h0;
            prot_out <= 2'h0;
            erase_all_out <= 1'b0;
            flash_go_out <= 1'b0;
            flash_op_out <= 2'h0;
            flash_blk_out <= 4'h0;
            bp_hit_out <= '0;
        end else begin
            locked_out <= locked_ff;
            test_allow_out <= !locked_ff;
            pair0_fn_out <= nxt_p0;
            pair1_fn_out <= nxt_p1;
            trace_out <= locked_ff ? TR_NONE : trc_ff;
            pins_used_out <= pins(eff_dbg, locked_ff ? TR_NONE : trc_ff, trst_ff);
            prot_out <= prot_ff;
            erase_all_out <= erase_ok;
            flash_go_out <= blk_ok;
            flash_op_out <= blk_op;
            flash_blk_out <= blk;
            bp_hit_out <= nxt_hit;
        end
    end
endmodule

// ### rtl/sdal_host.sv
// host end: drives link clock by divider, sends key pattern and frames,
// reads back answers, runs the lock sequence
// assumes the same 250 MHz core clock as the device
`timescale 1ns/1ps
module sdal_host import sdal_pkg::*; (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    sdal_link_if.host link,
    input wire logic acq_go_in,
    input wire logic pair_in,
    input wire logic cmd_go_in,
    input wire logic [3:0] op_in,
    input wire logic [3:0] arg_in,
    input wire logic [31:0] wdata_in,
    input wire logic lock_go_in,
    output logic busy_out,
    output logic done_out,
    output logic [31:0] rdata_out,
    output logic dev_rst_req_out
);
    typedef enum logic [1:0] {H_IDLE, H_BIT, H_GAP} sdal_hst_t;
    sdal_hst_t st_ff;
    logic [3:0] ph_ff;
    logic [5:0] nb_ff, len_ff;
    logic [39:0] sh_ff;
    logic [31:0] rx_ff;
    logic rd_ff, pair_ff, lck_ff, do_ff, oe_ff, seq_ff;
    logic [1:0] step_ff;
    logic ln_s1_ff, ln_s2_ff;

    // lock steps: key, program cells, protection, then reset
    function automatic logic [39:0] lock_frame(input logic [1:0] s);
        case (s)
            2'h0: return {LOCK_KEY, 4'h0, OP_WR_LOCK};
            2'h1: return {32'h0, 4'h0, OP_PRG_LOCK};
            default: return {32'h0, 2'h0, PROT_MAX, OP_SET_PROT};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // answer wire synchroniser
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ln_s1_ff <= 1'b1;
            ln_s2_ff <= 1'b1;
        end else begin
            ln_s1_ff <= link.line[pair_ff];
            ln_s2_ff <= ln_s1_ff;
        end
    end

    wire rd_bit = rd_ff && nb_ff >= 6'(CMD_W);
    wire last = nb_ff == len_ff - 6'h1;
    wire is_rd = op_in == OP_RD_LOCK || op_in == OP_RD_STAT;

    ////////////////////////////////////////////////////////////////////
    // bit engine: half period of six core cycles keeps clock under CPU/3
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_ff <= H_IDLE;
            ph_ff <= 4'h0;
            nb_ff <= 6'h0;
            len_ff <= 6'h0;
            sh_ff <= 40'h0;
            rx_ff <= 32'h0;
            rd_ff <= 1'b0;
            pair_ff <= 1'b0;
            lck_ff <= 1'b0;
            do_ff <= 1'b0;
            oe_ff <= 1'b0;
            seq_ff <= 1'b0;
            step_ff <= 2'h0;
            done_out <= 1'b0;
            rdata_out <= 32'h0;
            dev_rst_req_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            dev_rst_req_out <= 1'b0;
            case (st_ff)
                H_IDLE: begin
                    ph_ff <= 4'h0;
                    nb_ff <= 6'h0;
                    if (acq_go_in) begin
                        st_ff <= H_BIT; // key pattern inside the window
                        pair_ff <= pair_in;
                        sh_ff <= {24'h0, ACQ_KEY};
                        len_ff <= 6'(ACQ_W);
                        rd_ff <= 1'b0;
                    end else if (lock_go_in) begin
                        st_ff <= H_BIT;
                        seq_ff <= 1'b1;
                        step_ff <= 2'h0;
                        sh_ff <= lock_frame(2'h0);
                        len_ff <= 6'(FRAME_W);
                        rd_ff <= 1'b0;
                    end else if (cmd_go_in) begin
                        st_ff <= H_BIT;
                        sh_ff <= {wdata_in, arg_in, op_in};
                        len_ff <= 6'(FRAME_W);
                        rd_ff <= is_rd;
                    end
                end
                H_BIT: begin
                    ph_ff <= ph_ff + 4'h1;
                    if (ph_ff == 4'h0) begin
                        lck_ff <= 1'b0;
                        do_ff <= sh_ff[0];
                        oe_ff <= !rd_bit;
                    end
                    if (ph_ff == HALF_LAST + 4'h1) begin
                        lck_ff <= 1'b1;
                    end
                    if (ph_ff == BIT_LAST) begin
                        ph_ff <= 4'h0;
                        sh_ff <= {1'b0, sh_ff[39:1]};
                        nb_ff <= nb_ff + 6'h1;
                        if (rd_bit) begin
                            rx_ff <= {ln_s2_ff, rx_ff[31:1]};
                        end
                        if (last) begin
                            st_ff <= H_GAP;
                        end
                    end
                end
                H_GAP: begin
                    // idle gap lets the device release the wire first
                    lck_ff <= 1'b0;
                    oe_ff <= 1'b0;
                    ph_ff <= ph_ff + 4'h1;
                    if (ph_ff == BIT_LAST) begin
                        ph_ff <= 4'h0;
                        nb_ff <= 6'h0;
                        if (seq_ff && step_ff != 2'h2) begin
                            st_ff <= H_BIT;
                            step_ff <= step_ff + 2'h1;
                            sh_ff <= lock_frame(step_ff + 2'h1);
                        end else begin
                            st_ff <= H_IDLE;
                            done_out <= 1'b1;
                            rdata_out <= rx_ff;
                            dev_rst_req_out <= seq_ff;
                            seq_ff <= 1'b0;
                        end
                    end
                end
                default: st_ff <= H_IDLE;
            endcase
        end
    end

    assign busy_out = st_ff != H_IDLE;
    assign link.lck = {lck_ff & pair_ff, lck_ff & ~pair_ff};
    assign link.h_do = {do_ff & pair_ff, do_ff & ~pair_ff};
    assign link.h_oe = {oe_ff & pair_ff, oe_ff & ~pair_ff};
endmodule

// ### verification/sdal_checker.sv
// checker for the link pins between the host and device ends
// assumes one core clock and the shared sync reset of both ends
`timescale 1ns/1ps
module sdal_checker (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [1:0] lck,
    input wire logic [1:0] h_oe,
    input wire logic [1:0] d_do,
    input wire logic [1:0] d_oe
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////
    // six cycles per half keeps the link under a third of core rate
    sequence s_hi; lck[0] [*6]; endsequence
    sequence s_lo; !lck[0] [*6]; endsequence
    property p_hi; $rose(lck[0]) |-> s_hi; endproperty
    a_hi: assert property (p_hi) else $error("link clock high too short");
    property p_lo; $fell(lck[0]) |-> s_lo; endproperty
    a_lo: assert property (p_lo) else $error("link clock low too short");
    // shared wire: one talker, turns only while clock low
    property p_clash; (h_oe & d_oe) == 2'h0; endproperty
    a_clash: assert property (p_clash) else $error("both ends drive");
    property p_one; d_oe != 2'h3; endproperty
    a_one: assert property (p_one) else $error("device on both pairs");
    property p_hset; ((h_oe ^ $past(h_oe)) & lck) == 2'h0; endproperty
    a_hset: assert property (p_hset) else $error("host turns while high");
    property p_dset; ((d_oe ^ $past(d_oe)) & lck) == 2'h0; endproperty
    a_dset: assert property (p_dset) else $error("device turns while high");
    property p_dhold; ((d_do ^ $past(d_do)) & d_oe & lck & $past(lck)) == 2'h0; endproperty
    a_dhold: assert property (p_dhold) else $error("device data moves");
    property p_turn; (d_oe & ~$past(d_oe) & $past(h_oe)) == 2'h0; endproperty
    a_turn: assert property (p_turn) else $error("device drives too early");
endmodule

// ### verification/serial_debug_acquire_and_lock_test.sv
// bench: host and device ends joined by the link, driven via host commands
// assumes the device is reset only while the link is idle
`timescale 1ns/1ps
module serial_debug_acquire_and_lock_test import sdal_pkg::*; ;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, cwe = 1'b0, ago = 1'b0, pr = 1'b0;
    logic cgo = 1'b0, lgo = 1'b0, lk, ta, done;
    logic [5:0] cfg = 6'h00;
    logic [15:0] blk = 16'h0008;
    logic [31:0] pc = 32'h0, lit = 32'h0, wd = 32'h0, rd;
    logic [3:0] op = 4'h0, arg = 4'h0, pins;
    logic [1:0] f0, f1, prot, tr;
    logic [7:0] bp;
    int err_count = 0;
    int n_tests = 0;
    sdal_link_if sdal_link_if_inst ();
    sdal_dev sdal_dev_inst (.core_clk_in(clk), .sys_rst_in(rst), .por_in(por),
        .link(sdal_link_if_inst.dev), .jtag_cfg_we_in(cwe), .jtag_cfg_in(cfg),
        .blk_lock_in(blk), .cpu_pc_in(pc), .cpu_lit_in(lit), .locked_out(lk),
        .test_allow_out(ta), .pair0_fn_out(f0), .pair1_fn_out(f1), .trace_out(tr),
        .pins_used_out(pins), .prot_out(prot), .erase_all_out(), .flash_go_out(),
        .flash_op_out(), .flash_blk_out(), .bp_hit_out(bp));
    sdal_host sdal_host_inst (.core_clk_in(clk), .sys_rst_in(rst),
        .link(sdal_link_if_inst.host), .acq_go_in(ago), .pair_in(pr), .cmd_go_in(cgo),
        .op_in(op), .arg_in(arg), .wdata_in(wd), .lock_go_in(lgo), .busy_out(),
        .done_out(done), .rdata_out(rd), .dev_rst_req_out());
    sdal_checker sdal_checker_inst (.core_clk_in(clk), .sys_rst_in(rst),
        .lck(sdal_link_if_inst.lck), .h_oe(sdal_link_if_inst.h_oe),
        .d_do(sdal_link_if_inst.d_do), .d_oe(sdal_link_if_inst.d_oe));
    ////////////////////////////////////////////////////////////////
    // 250 MHz core clock
    always #2 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic reset(input logic p);
        por <= p;
        rst <= 1'b1;
        tick(2);
        por <= 1'b0;
        rst <= 1'b0;
        tick(1);
    endtask
    // bounded wait; a lock run is three frames long
    task automatic waitd();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n == 2000)
            err_count++;
        tick(3);
    endtask
    task automatic fr(input logic [3:0] o, input logic [3:0] a, input logic [31:0] d);
        op <= o;
        arg <= a;
        wd <= d;
        cgo <= 1'b1;
        @(posedge clk);
        cgo <= 1'b0;
        waitd();
    endtask
    task automatic refused(input logic e);
        fr(OP_RD_STAT, 4'h0, 32'h0);
        chk(rd[ST_REFUSED], e);
    endtask
    task automatic acq(input logic p);
        pr <= p;
        ago <= 1'b1;
        @(posedge clk);
        ago <= 1'b0;
        waitd();
    endtask
    task automatic jcfg(input logic [5:0] v);
        cfg <= v;
        cwe <= 1'b1;
        @(posedge clk);
        cwe <= 1'b0;
        tick(3);
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog well past the expected twenty thousand cycles
    initial begin
        tick(60000);
        err_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        reset(1'b1);
        tick(2100);
        acq(1'b0);
        chk(f0, FN_JTAG);
        reset(1'b0);
        acq(1'b1);
        chk(f1, FN_SERIAL);
        chk(f0 === FN_SERIAL, 1'b0);
        reset(1'b0);
        acq(1'b0);
        chk(f0, FN_SERIAL);
        fr(OP_RD_LOCK, 4'h0, 32'h0);
        chk(rd, 32'h0);
        fr(OP_SET_PROT, 4'h2, 32'h0);
        fr(OP_WR_LOCK, 4'h0, LOCK_KEY);
        refused(1'b1);
        fr(OP_SET_PROT, 4'h1, 32'h0);
        chk(prot, 2'h2);
        fr(OP_ERASE_ALL, 4'h0, 32'h0);
        chk(prot, 2'h0);
        for (int i = 0; i < 3; i++) begin
            fr(OP_BLK, 4'(i), (i == 1) ? 32'h2 : 32'h3);
            refused(i == 0);
        end
        fr(OP_SCAN, 4'h0, 32'h0);
        refused(1'b1);
        for (int i = 0; i < NBP; i++)
            fr(OP_SET_BP, 4'(8 + i), 32'h100 + i);
        pc <= 32'h106;
        lit <= 32'h105;
        tick(3);
        chk(bp, 8'h00);
        pc <= 32'h105;
        lit <= 32'h107;
        tick(3);
        chk(bp, 8'hA0);
        fr(OP_SET_CFG, 4'h0, 32'h06);
        chk(pins, 4'h3);
        fr(OP_SET_CFG, 4'h0, 32'h05);
        chk(pins, 4'h3);
        fr(OP_SET_CFG, 4'h0, 32'h0A);
        chk(pins, 4'h7);
        chk(tr, TR_PAR);
        fr(OP_SET_CFG, 4'h0, 32'h29);
        chk(pins, 4'h9);
        chk(f0, FN_JTAG);
        jcfg(6'h19);
        chk(pins, 4'hA);
        jcfg(6'h00);
        chk(f0, FN_GPIO);
        reset(1'b0);
        acq(1'b0);
        chk(f0, FN_SERIAL);
        fr(OP_WR_LOCK, 4'h0, LOCK_KEY);
        refused(1'b0);
        lgo <= 1'b1;
        @(posedge clk);
        lgo <= 1'b0;
        waitd();
        chk(lk, 1'b0);
        chk(prot, PROT_MAX);
        reset(1'b0);
        tick(1);
        chk({lk, ta}, 2'h2);
        acq(1'b0);
        chk(f0 === FN_SERIAL, 1'b0);
        fr(OP_RD_LOCK, 4'h0, 32'h0);
        chk(rd, 32'hFFFFFFFF);
        print_verdict();
    end
endmodule
